// ===== src/acx_pkg.sv
// constants and types shared by the accumulator / x-register command block
package acx_pkg;
	// instruction codes of the frame instruction byte
	localparam logic [7:0] INS_IMMEDIATE_A_X = 8'h21;
	localparam logic [7:0] INS_ACCU_AXIS = 8'h22;
	localparam logic [7:0] INS_ACCU_GLOBAL = 8'h23;
	localparam logic [7:0] INS_CLR_FLAGS = 8'h24;
	// type codes of immediate_a_with_xreg
	localparam logic [7:0] OP_ADD = 8'h00;
	localparam logic [7:0] OP_SUB = 8'h01;
	localparam logic [7:0] OP_MUL = 8'h02;
	localparam logic [7:0] OP_DIV = 8'h03;
	localparam logic [7:0] OP_MOD = 8'h04;
	localparam logic [7:0] OP_AND = 8'h05;
	localparam logic [7:0] OP_OR = 8'h06;
	localparam logic [7:0] OP_XOR = 8'h07;
	localparam logic [7:0] OP_NOT = 8'h08;
	localparam logic [7:0] OP_LOAD = 8'h09;
	localparam logic [7:0] OP_SWAP = 8'h0a;
	// type codes of the flag clear instruction
	localparam logic [7:0] CLR_ALL = 8'h00;
	localparam logic [7:0] CLR_LAST = 8'h05;
	// error flag positions, type n clears bit n-1
	localparam int FLAG_W = 5;
	localparam int FLG_TIMEOUT = 0;
	localparam int FLG_ALARM = 1;
	localparam int FLG_DEVIATION = 2;
	localparam int FLG_POSITION = 3;
	localparam int FLG_SHUTDOWN = 4;
	// reply status codes
	localparam logic [7:0] STAT_OK = 8'h64;
	localparam logic [7:0] STAT_CSUM_ERR = 8'h01;
	localparam logic [7:0] STAT_BAD_CMD = 8'h02;
	// frame layout
	localparam logic [3:0] FRAME_LEN = 4'h9;
	localparam int FB_ADDR = 0;
	localparam int FB_INSTR = 1;
	localparam int FB_TYPE = 2;
	localparam int FB_BANK = 3;
	localparam int FB_CSUM = 8;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_ACCU = 8'h08;
	localparam logic [7:0] OFF_XREG = 8'h0c;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFF_IRQ_EN = 8'h14;
	localparam logic [7:0] OFF_IRQ_CLR = 8'h18;
	localparam logic [7:0] OFF_REPLY = 8'h1c;
	// control fields: bit 0 enable, bits 15:8 own module address
	localparam int CTRL_EN = 0;
	localparam logic [31:0] CTRL_RST = 32'h0000_0101;
	localparam logic [31:0] CTRL_MASK = 32'h0000_ff01;
	// interrupt events
	localparam int IRQ_W = 5;
	localparam int EV_DONE = 0;
	localparam int EV_CSUM = 1;
	localparam int EV_BADCMD = 2;
	localparam int EV_DIVZERO = 3;
	localparam int EV_FLAG = 4;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// execution states
	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DIV, ST_REPLY} acx_state_t;
endpackage : acx_pkg

// ===== src/acx_divider.sv
// iterative unsigned restoring divider, one quotient bit per cycle
`timescale 1ns/1ns
`default_nettype none
module acx_divider #(
	parameter int W = 32
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic [W-1:0] dividend,
	input wire logic [W-1:0] divisor,
	output logic done,
	output logic [W-1:0] quot,
	output logic [W-1:0] rem
);
	initial begin
		if (W < 2) $error("acx_divider: W must be at least 2");
	end

	logic [W-1:0] q_r, q_nxt, r_r, r_nxt, d_r, d_nxt;
	logic [$clog2(W+1)-1:0] n_r, n_nxt;
	logic run_r, run_nxt, done_r, done_nxt;
	logic [W:0] trial;

	// next state: shift in one dividend bit, subtract when it fits
	always_comb begin
		q_nxt = q_r;
		r_nxt = r_r;
		d_nxt = d_r;
		n_nxt = n_r;
		run_nxt = run_r;
		done_nxt = 1'b0;
		trial = {r_r, q_r[W-1]} - {1'b0, d_r};
		if (start) begin
			q_nxt = dividend;
			r_nxt = '0;
			d_nxt = divisor;
			n_nxt = $clog2(W+1)'(W);
			run_nxt = 1'b1;
		end else if (run_r) begin
			if (!trial[W]) begin
				r_nxt = trial[W-1:0];
				q_nxt = {q_r[W-2:0], 1'b1};
			end else begin
				r_nxt = {r_r[W-2:0], q_r[W-1]};
				q_nxt = {q_r[W-2:0], 1'b0};
			end
			n_nxt = n_r - 1'b1;
			if (n_r == 1) begin
				run_nxt = 1'b0;
				done_nxt = 1'b1;
			end
		end
	end

	// state registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q_r <= '0;
			r_r <= '0;
			d_r <= '0;
			n_r <= '0;
			run_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			q_r <= q_nxt;
			r_r <= r_nxt;
			d_r <= d_nxt;
			n_r <= n_nxt;
			run_r <= run_nxt;
			done_r <= done_nxt;
		end
	end

	assign done = done_r;
	assign quot = q_r;
	assign rem = r_r;
endmodule : acx_divider
`default_nettype wire

// ===== src/acx_core.sv
// command interpreter for accumulator / x-register immediate_a, parameter transfer and flag clear
// How it works
// - instruction 33 combines accumulator and x register per type, result to accumulator except types 8 and 9 (x register) and 10 (both)
// - type 0 adds x to accumulator, type 1 subtracts x from it
// - type 2 multiplies, 3 divides, 4 keeps the division remainder
// - types 5, 6, 7 give bitwise and, or, xor with x
// - type 8 inverts the x register bitwise
// - type 9 copies the accumulator into the x register
// - type 10 exchanges accumulator and x register at once
// - instruction 34 writes accumulator to axis parameter type of motor bank
// - instruction 35 writes accumulator to global parameter type of bank
// - instruction 36 clears error flags by type, type 0 clears all
// - types 1 to 5 clear timeout, alarm, deviation, position, shutdown flag
// - direct commands reply with status 100, 1 on a checksum error or 2 on a bad command, and a meaningless value
`timescale 1ns/1ns
`default_nettype none
module acx_core #(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] frm_byte,
	input wire logic frm_valid,
	output logic frm_ready,
	input wire logic pgm_valid,
	input wire logic [7:0] pgm_instr,
	input wire logic [7:0] pgm_type,
	input wire logic [7:0] pgm_bank,
	output logic pgm_ready,
	output logic rep_valid,
	input wire logic rep_ready,
	output logic [7:0] rep_status,
	output logic [7:0] rep_instr,
	output logic [31:0] rep_value,
	output logic par_wr,
	output logic par_global,
	output logic [7:0] par_index,
	output logic [7:0] par_bank,
	output logic [31:0] par_data,
	input wire logic [acx_pkg::FLAG_W-1:0] flag_set,
	output logic [acx_pkg::FLAG_W-1:0] err_flags,
	output logic irq
);
	initial begin
		if (ADDR_W < 5) $error("acx_core: ADDR_W too small for the register map");
	end

	acx_pkg::acx_state_t st_r, st_nxt;
	logic [7:0] fb_r [0:8];
	logic [7:0] fb_nxt [0:8];
	logic [3:0] cnt_r, cnt_nxt;
	logic [31:0] accu_r, accu_nxt, xreg_r, xreg_nxt;
	logic [7:0] ins_r, ins_nxt, typ_r, typ_nxt, bank_r, bank_nxt, stat_r, stat_nxt;
	logic direct_r, direct_nxt, par_wr_r, par_wr_nxt, par_glb_r, par_glb_nxt;
	logic [acx_pkg::FLAG_W-1:0] flg_r, flg_nxt, flg_clr;
	logic [acx_pkg::IRQ_W-1:0] ev, ist_r, ist_nxt, ien_r, ien_nxt;
	logic [31:0] ctrl_r, ctrl_nxt;
	logic [7:0] csum;
	logic div_start, div_done, a_neg, x_neg, div_mod_r, div_mod_nxt;
	logic [31:0] a_mag, x_mag, quot, rem;
	// bus side
	logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt, bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt, bmask, rd_word;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic bus_wr, rd_hit;
	logic [7:0] wr_off, rd_off;

	// checksum over the eight leading frame bytes
	always_comb begin
		csum = 8'h00;
		for (int i = 0; i < 8; i++) begin
			csum = csum + fb_r[i];
		end
	end

	// signed division runs on magnitudes
	assign a_neg = accu_r[31];
	assign x_neg = xreg_r[31];
	assign a_mag = a_neg ? -accu_r : accu_r;
	assign x_mag = x_neg ? -xreg_r : xreg_r;

	acx_divider #(
		.W(32)
	) u_div (
		.clk(clk),
		.sys_rst(sys_rst),
		.start(div_start),
		.dividend(a_mag),
		.divisor(x_mag),
		.done(div_done),
		.quot(quot),
		.rem(rem)
	);

	// bus write decode, byte lanes folded into a bit mask
	assign bus_wr = aw_hold_r && w_hold_r && !bvalid_r;
	assign wr_off = 8'(awaddr_r);
	assign bmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

	// frame receive, command execution, flags and interrupt state
	always_comb begin
		st_nxt = st_r;
		fb_nxt = fb_r;
		cnt_nxt = cnt_r;
		accu_nxt = accu_r;
		xreg_nxt = xreg_r;
		ins_nxt = ins_r;
		typ_nxt = typ_r;
		bank_nxt = bank_r;
		stat_nxt = stat_r;
		direct_nxt = direct_r;
		par_wr_nxt = 1'b0;
		par_glb_nxt = par_glb_r;
		div_mod_nxt = div_mod_r;
		div_start = 1'b0;
		flg_clr = '0;
		ev = '0;
		ctrl_nxt = ctrl_r;
		ien_nxt = ien_r;
		pgm_ready = 1'b0;
		// register writes from software, execution below overrides them
		if (bus_wr) begin
			case (wr_off)
				acx_pkg::OFF_CTRL: ctrl_nxt = ((ctrl_r & ~bmask) | (wdata_r & bmask)) & acx_pkg::CTRL_MASK;
				acx_pkg::OFF_ACCU: accu_nxt = (accu_r & ~bmask) | (wdata_r & bmask);
				acx_pkg::OFF_XREG: xreg_nxt = (xreg_r & ~bmask) | (wdata_r & bmask);
				acx_pkg::OFF_IRQ_EN: ien_nxt = (ien_r & ~bmask[acx_pkg::IRQ_W-1:0]) | (wdata_r[acx_pkg::IRQ_W-1:0] & bmask[acx_pkg::IRQ_W-1:0]);
				default: ;
			endcase
		end
		// bytes fill the frame in arrival order
		if (frm_valid && frm_ready) begin
			fb_nxt[cnt_r] = frm_byte;
			cnt_nxt = cnt_r + 4'h1;
		end
		case (st_r)
			acx_pkg::ST_IDLE: begin
				if (cnt_r == acx_pkg::FRAME_LEN) begin
					cnt_nxt = 4'h0;
					ins_nxt = fb_r[acx_pkg::FB_INSTR];
					typ_nxt = fb_r[acx_pkg::FB_TYPE];
					bank_nxt = fb_r[acx_pkg::FB_BANK];
					direct_nxt = 1'b1;
					// frames for other addresses are dropped silently
					if (fb_r[acx_pkg::FB_ADDR] == ctrl_r[15:8]) begin
						if (csum == fb_r[acx_pkg::FB_CSUM]) begin
							st_nxt = acx_pkg::ST_EXEC;
						end else begin
							stat_nxt = acx_pkg::STAT_CSUM_ERR;
							ev[acx_pkg::EV_CSUM] = 1'b1;
							st_nxt = acx_pkg::ST_REPLY;
						end
					end
				end else begin
					pgm_ready = ctrl_r[acx_pkg::CTRL_EN];
					if (pgm_valid && ctrl_r[acx_pkg::CTRL_EN]) begin
						ins_nxt = pgm_instr;
						typ_nxt = pgm_type;
						bank_nxt = pgm_bank;
						direct_nxt = 1'b0;
						st_nxt = acx_pkg::ST_EXEC;
					end
				end
			end
			acx_pkg::ST_EXEC: begin
				stat_nxt = acx_pkg::STAT_OK;
				st_nxt = direct_r ? acx_pkg::ST_REPLY : acx_pkg::ST_IDLE;
				case (ins_r)
					acx_pkg::INS_IMMEDIATE_A_X: begin
						case (typ_r)
							acx_pkg::OP_ADD: accu_nxt = accu_r + xreg_r;
							acx_pkg::OP_SUB: accu_nxt = accu_r - xreg_r;
							acx_pkg::OP_MUL: accu_nxt = accu_r * xreg_r;
							acx_pkg::OP_DIV, acx_pkg::OP_MOD: begin
								if (xreg_r == 32'h0000_0000) begin
									ev[acx_pkg::EV_DIVZERO] = 1'b1;
								end else begin
									div_start = 1'b1;
									div_mod_nxt = (typ_r == acx_pkg::OP_MOD);
									st_nxt = acx_pkg::ST_DIV;
								end
							end
							acx_pkg::OP_AND: accu_nxt = accu_r & xreg_r;
							acx_pkg::OP_OR: accu_nxt = accu_r | xreg_r;
							acx_pkg::OP_XOR: accu_nxt = accu_r ^ xreg_r;
							acx_pkg::OP_NOT: xreg_nxt = ~xreg_r;
							acx_pkg::OP_LOAD: xreg_nxt = accu_r;
							acx_pkg::OP_SWAP: begin
								accu_nxt = xreg_r;
								xreg_nxt = accu_r;
							end
							default: begin
								stat_nxt = acx_pkg::STAT_BAD_CMD;
								ev[acx_pkg::EV_BADCMD] = 1'b1;
							end
						endcase
					end
					acx_pkg::INS_ACCU_AXIS: begin
						par_wr_nxt = 1'b1;
						par_glb_nxt = 1'b0;
					end
					acx_pkg::INS_ACCU_GLOBAL: begin
						par_wr_nxt = 1'b1;
						par_glb_nxt = 1'b1;
					end
					acx_pkg::INS_CLR_FLAGS: begin
						if (typ_r == acx_pkg::CLR_ALL) begin
							flg_clr = '1;
						end else if (typ_r <= acx_pkg::CLR_LAST) begin
							flg_clr[typ_r[2:0] - 3'h1] = 1'b1;
						end else begin
							stat_nxt = acx_pkg::STAT_BAD_CMD;
							ev[acx_pkg::EV_BADCMD] = 1'b1;
						end
					end
					default: begin
						stat_nxt = acx_pkg::STAT_BAD_CMD;
						ev[acx_pkg::EV_BADCMD] = 1'b1;
					end
				endcase
				ev[acx_pkg::EV_DONE] = 1'b1;
			end
			acx_pkg::ST_DIV: begin
				// sign fix, remainder follows the dividend sign
				if (div_done) begin
					if (div_mod_r) begin
						accu_nxt = a_neg ? -rem : rem;
					end else begin
						accu_nxt = (a_neg ^ x_neg) ? -quot : quot;
					end
					st_nxt = direct_r ? acx_pkg::ST_REPLY : acx_pkg::ST_IDLE;
				end
			end
			acx_pkg::ST_REPLY: begin
				if (rep_ready) begin
					st_nxt = acx_pkg::ST_IDLE;
				end
			end
			default: st_nxt = acx_pkg::ST_IDLE;
		endcase
		// a flag raised in the clearing cycle survives
		flg_nxt = (flg_r & ~flg_clr) | flag_set;
		ev[acx_pkg::EV_FLAG] = |(flag_set & ~flg_r);
		ist_nxt = ist_r | ev;
		if (bus_wr && wr_off == acx_pkg::OFF_IRQ_CLR) begin
			ist_nxt = (ist_r & ~(wdata_r[acx_pkg::IRQ_W-1:0] & bmask[acx_pkg::IRQ_W-1:0])) | ev;
		end
	end

	// command state registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= acx_pkg::ST_IDLE;
			for (int i = 0; i < 9; i++) begin
				fb_r[i] <= 8'h00;
			end
			cnt_r <= 4'h0;
			accu_r <= 32'h0000_0000;
			xreg_r <= 32'h0000_0000;
			ins_r <= 8'h00;
			typ_r <= 8'h00;
			bank_r <= 8'h00;
			stat_r <= 8'h00;
			direct_r <= 1'b0;
			par_wr_r <= 1'b0;
			par_glb_r <= 1'b0;
			div_mod_r <= 1'b0;
			flg_r <= '0;
			ist_r <= '0;
			ien_r <= '0;
			ctrl_r <= acx_pkg::CTRL_RST;
		end else begin
			st_r <= st_nxt;
			fb_r <= fb_nxt;
			cnt_r <= cnt_nxt;
			accu_r <= accu_nxt;
			xreg_r <= xreg_nxt;
			ins_r <= ins_nxt;
			typ_r <= typ_nxt;
			bank_r <= bank_nxt;
			stat_r <= stat_nxt;
			direct_r <= direct_nxt;
			par_wr_r <= par_wr_nxt;
			par_glb_r <= par_glb_nxt;
			div_mod_r <= div_mod_nxt;
			flg_r <= flg_nxt;
			ist_r <= ist_nxt;
			ien_r <= ien_nxt;
			ctrl_r <= ctrl_nxt;
		end
	end

	// read mux over the register map
	always_comb begin
		rd_off = 8'(s_axi_araddr);
		rd_hit = 1'b1;
		case (rd_off)
			acx_pkg::OFF_CTRL: rd_word = ctrl_r;
			acx_pkg::OFF_STATUS: rd_word = {24'h00_0000, (st_r != acx_pkg::ST_IDLE), 2'h0, flg_r};
			acx_pkg::OFF_ACCU: rd_word = accu_r;
			acx_pkg::OFF_XREG: rd_word = xreg_r;
			acx_pkg::OFF_IRQ_STAT: rd_word = {27'h000_0000, ist_r};
			acx_pkg::OFF_IRQ_EN: rd_word = {27'h000_0000, ien_r};
			acx_pkg::OFF_IRQ_CLR: rd_word = 32'h0000_0000;
			acx_pkg::OFF_REPLY: rd_word = {16'h0000, ins_r, stat_r};
			default: begin
				rd_word = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// axi4-lite channel handshakes, address and data taken in either order
	always_comb begin
		aw_hold_nxt = aw_hold_r;
		w_hold_nxt = w_hold_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_nxt = 1'b1;
			wdata_nxt = s_axi_wdata;
		end
		if (bus_wr) begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = (wr_off[7:5] == 3'h0 && wr_off[1:0] == 2'h0 && wr_off != acx_pkg::OFF_STATUS
				&& wr_off != acx_pkg::OFF_IRQ_STAT && wr_off != acx_pkg::OFF_REPLY)
				? acx_pkg::RESP_OKAY : acx_pkg::RESP_SLVERR;
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rdata_nxt = rd_word;
			rresp_nxt = rd_hit ? acx_pkg::RESP_OKAY : acx_pkg::RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	// bus registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= 32'h0000_0000;
			bvalid_r <= 1'b0;
			bresp_r <= acx_pkg::RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= acx_pkg::RESP_OKAY;
		end else begin
			aw_hold_r <= aw_hold_nxt;
			w_hold_r <= w_hold_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// outputs
	assign s_axi_awready = !aw_hold_r && !bvalid_r;
	assign s_axi_wready = !w_hold_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign frm_ready = (cnt_r != acx_pkg::FRAME_LEN) && ctrl_r[acx_pkg::CTRL_EN];
	assign rep_valid = (st_r == acx_pkg::ST_REPLY);
	assign rep_status = stat_r;
	assign rep_instr = ins_r;
	assign rep_value = accu_r;  // content carries no meaning
	assign par_wr = par_wr_r;
	assign par_global = par_glb_r;
	assign par_index = typ_r;
	assign par_bank = bank_r;
	assign par_data = accu_r;
	assign err_flags = flg_r;
	assign irq = |(ist_r & ien_r);
endmodule : acx_core
`default_nettype wire

// ===== verification/acx_host.sv
// host model: sends command frames and takes the replies
`timescale 1ns/1ns
`default_nettype none
module acx_host (
	input wire logic clk,
	output logic [7:0] frm_byte,
	output logic frm_valid,
	input wire logic frm_ready,
	input wire logic rep_valid,
	output logic rep_ready,
	input wire logic [7:0] rep_status,
	input wire logic [31:0] rep_value
);
	// idle link at time zero
	initial begin
		frm_byte = 8'h00;
		frm_valid = 1'b0;
		rep_ready = 1'b0;
	end
	task automatic send(input logic [7:0] ad, ins, ty, bk, input logic [31:0] v, input logic bad);
		logic [7:0] f [9];
		logic [7:0] s;
		f = '{ad, ins, ty, bk, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
		s = 8'h00;
		for (int i = 0; i < 8; i++) begin
			s = s + f[i];
		end
		f[8] = s ^ {7'h00, bad};
		for (int i = 0; i < 9; i++) begin
			frm_byte <= f[i];
			frm_valid <= 1'b1;
			do @(posedge clk); while (frm_ready !== 1'b1);
		end
		frm_valid <= 1'b0;
		// released line shows the inverse, not a stale byte
		frm_byte <= ~f[8];
	endtask : send
	// reply taken after a chosen stall
	task automatic take(input int stall, output logic [7:0] st, output logic [31:0] val);
		repeat (stall) @(posedge clk);
		rep_ready <= 1'b1;
		do @(posedge clk); while (rep_valid !== 1'b1);
		st = rep_status;
		val = rep_value;
		rep_ready <= 1'b0;
	endtask : take
endmodule : acx_host
`default_nettype wire

// ===== verification/acx_core_chk.sv
// concurrent checks on the ports of the command block
`timescale 1ns/1ns
`default_nettype none
module acx_core_chk (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic rep_valid,
	input wire logic rep_ready,
	input wire logic [7:0] rep_status,
	input wire logic [7:0] rep_instr,
	input wire logic [31:0] rep_value,
	input wire logic par_wr,
	input wire logic [acx_pkg::FLAG_W-1:0] flag_set,
	input wire logic [acx_pkg::FLAG_W-1:0] err_flags
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// reply holds until taken
	chk_rep_hold: assert property (
		rep_valid && !rep_ready |=> rep_valid && $stable(rep_status) && $stable(rep_value))
		else $error("reply changed before taken");
	// transfer replies report success or a checksum error
	chk_xfer_okay: assert property (
		rep_valid && (rep_instr == acx_pkg::INS_ACCU_AXIS || rep_instr == acx_pkg::INS_ACCU_GLOBAL)
		|-> rep_status == acx_pkg::STAT_OK || rep_status == acx_pkg::STAT_CSUM_ERR)
		else $error("transfer reply not success");
	// one write strobe per transfer
	chk_par_pulse: assert property (
		par_wr |=> !par_wr)
		else $error("write strobe too long");
	// an event always lands in its flag
	chk_flag_set: assert property (
		|flag_set |=> (err_flags & $past(flag_set)) == $past(flag_set))
		else $error("error flag not set by its event");
	// write answer in time
	chk_b_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	// read answer in time
	chk_r_answer: assert property (
		s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
		else $error("read data late");
	// no new write while a response waits
	chk_aw_block: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted during response");
	// no new read while data waits
	chk_ar_block: assert property (
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted during data");
endmodule : acx_core_chk
bind acx_core acx_core_chk u_chk (.*);
`default_nettype wire

// ===== verification/test_acx_core.sv
// self-checking bench for the accumulator / x-register command block
`timescale 1ns/1ns
`default_nettype none
module test_acx_core;
	logic clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, frm_valid, frm_ready, pgm_valid, pgm_ready;
	logic rep_valid, rep_ready, par_wr, par_global, irq;
	logic [7:0] awaddr, araddr, frm_byte, pgm_instr, pgm_type, pgm_bank, rep_status, rep_instr, par_index, par_bank, st;
	logic [31:0] wdata, rdata, rep_value, par_data, d, a, x, ea, ex;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [4:0] flag_set, err_flags, ef;
	logic [48:0] par_cap;
	int errors, checks_done;
	acx_core #(.ADDR_W(8)) DUT (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .frm_byte(frm_byte),
		.frm_valid(frm_valid), .frm_ready(frm_ready), .pgm_valid(pgm_valid), .pgm_instr(pgm_instr),
		.pgm_type(pgm_type), .pgm_bank(pgm_bank), .pgm_ready(pgm_ready), .rep_valid(rep_valid),
		.rep_ready(rep_ready), .rep_status(rep_status), .rep_instr(rep_instr), .rep_value(rep_value),
		.par_wr(par_wr), .par_global(par_global), .par_index(par_index), .par_bank(par_bank),
		.par_data(par_data), .flag_set(flag_set), .err_flags(err_flags), .irq(irq));
	acx_host u_host (.clk(clk), .frm_byte(frm_byte), .frm_valid(frm_valid), .frm_ready(frm_ready),
		.rep_valid(rep_valid), .rep_ready(rep_ready), .rep_status(rep_status), .rep_value(rep_value));
	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// last parameter write seen
	always @(posedge clk) begin
		if (par_wr === 1'b1) par_cap <= {par_global, par_index, par_bank, par_data};
	end
	task automatic chk(input logic [31:0] got, exp, input string m);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("Error %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	// bus write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] ad, input logic [31:0] v, input logic [1:0] er);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		awaddr <= ad;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge clk);
			if (!ta && awready === 1'b1) awvalid <= 1'b0;
			if (!tw && wready === 1'b1) wvalid <= 1'b0;
			ta = ta || awready === 1'b1;
			tw = tw || wready === 1'b1;
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er}, "write response");
	endtask : wr
	task automatic rd(input logic [7:0] ad, output logic [31:0] v, output logic [1:0] rs);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		v = rdata;
		rs = rresp;
	endtask : rd
	// one immediate_a frame, operands in and out
	task automatic immediate_a(input logic [7:0] ty, input logic [31:0] va, vx, input logic [7:0] es,
		input logic [31:0] xa, xx);
		wr(acx_pkg::OFF_ACCU, va, acx_pkg::RESP_OKAY);
		wr(acx_pkg::OFF_XREG, vx, acx_pkg::RESP_OKAY);
		u_host.send(8'h01, acx_pkg::INS_IMMEDIATE_A_X, ty, 8'h00, 32'h0, 1'b0);
		u_host.take(2, st, d);
		chk({24'h0, st}, {24'h0, es}, "immediate_a status");
		rd(acx_pkg::OFF_ACCU, d, r);
		chk(d, xa, "accumulator");
		rd(acx_pkg::OFF_XREG, d, r);
		chk(d, xx, "x register");
	endtask : immediate_a
	task automatic complete_run;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run
	// watchdog
	initial begin
		#1000000;
		errors++;
		$display("Error %0t run timed out", $time);
		complete_run();
	end
	// main sequence
	initial begin
		errors = 0;
		checks_done = 0;
		sys_rst = 1'b1;
		wstrb = 4'hf;
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
		{pgm_valid, pgm_instr, pgm_type, pgm_bank, flag_set} = '0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(acx_pkg::OFF_CTRL, d, r);
		chk(d, acx_pkg::CTRL_RST, "control reset value");
		rd(8'h20, d, r);
		chk({r, d[29:0]}, {acx_pkg::RESP_SLVERR, 30'h0}, "unmapped read");
		wr(acx_pkg::OFF_STATUS, 32'h1, acx_pkg::RESP_SLVERR);
		$display("register test done");
		a = 32'hffff_fff3;
		x = 32'h0000_0005;
		for (int t = 0; t < 11; t++) begin
			ea = a;
			ex = x;
			case (t)
				0: ea = a + x;
				1: ea = a - x;
				2: ea = a * x;
				3: ea = $signed(a) / $signed(x);
				4: ea = $signed(a) % $signed(x);
				5: ea = a & x;
				6: ea = a | x;
				7: ea = a ^ x;
				8: ex = ~x;
				9: ex = a;
				default: begin
					ea = x;
					ex = a;
				end
			endcase
			immediate_a(t[7:0], a, x, acx_pkg::STAT_OK, ea, ex);
		end
		immediate_a(8'h0b, a, x, acx_pkg::STAT_BAD_CMD, a, x);
		u_host.send(8'h01, acx_pkg::INS_IMMEDIATE_A_X, 8'h00, 8'h00, 32'h0, 1'b1);
		u_host.take(0, st, d);
		chk({24'h0, st}, {24'h0, acx_pkg::STAT_CSUM_ERR}, "bad checksum status");
		u_host.send(8'h02, acx_pkg::INS_IMMEDIATE_A_X, 8'h00, 8'h00, 32'h0, 1'b0);
		repeat (5) @(posedge clk);
		chk({31'h0, rep_valid}, 32'h0, "reply to foreign frame");
		rd(acx_pkg::OFF_ACCU, d, r);
		chk(d, a, "accu after refused");
		$display("immediate_a test done");
		wr(acx_pkg::OFF_ACCU, 32'h1234_5678, acx_pkg::RESP_OKAY);
		u_host.send(8'h01, acx_pkg::INS_ACCU_AXIS, 8'h2a, 8'h02, 32'hffff_ffff, 1'b0);
		u_host.take(3, st, d);
		chk({24'h0, st}, {24'h0, acx_pkg::STAT_OK}, "axis transfer status");
		chk(par_cap[31:0], 32'h1234_5678, "axis transfer data");
		chk({15'h0, par_cap[48:32]}, {15'h0, 1'b0, 8'h2a, 8'h02}, "axis transfer target");
		wr(acx_pkg::OFF_ACCU, 32'h0bad_cafe, acx_pkg::RESP_OKAY);
		pgm_instr <= acx_pkg::INS_ACCU_GLOBAL;
		pgm_type <= 8'h07;
		pgm_bank <= 8'h03;
		pgm_valid <= 1'b1;
		do @(posedge clk); while (pgm_ready !== 1'b1);
		pgm_valid <= 1'b0;
		repeat (4) @(posedge clk);
		chk(par_cap[31:0], 32'h0bad_cafe, "global transfer data");
		chk({15'h0, par_cap[48:32]}, {15'h0, 1'b1, 8'h07, 8'h03}, "global transfer target");
		$display("transfer test done");
		for (int t = 0; t < 6; t++) begin
			flag_set <= 5'h1f;
			@(posedge clk);
			flag_set <= 5'h00;
			u_host.send(8'h01, acx_pkg::INS_CLR_FLAGS, t[7:0], 8'h00, 32'h0, 1'b0);
			u_host.take(1, st, d);
			ef = (t == 0) ? 5'h00 : ~(5'h01 << (t - 1));
			chk({27'h0, err_flags}, {27'h0, ef}, "error flags after clear");
		end
		$display("flag test done");
		wr(acx_pkg::OFF_IRQ_CLR, 32'h1f, acx_pkg::RESP_OKAY);
		wr(acx_pkg::OFF_IRQ_EN, 32'h08, acx_pkg::RESP_OKAY);
		immediate_a(acx_pkg::OP_DIV, 32'h7, 32'h0, acx_pkg::STAT_OK, 32'h7, 32'h0);
		chk({31'h0, irq}, 32'h1, "interrupt on divide by zero");
		wr(acx_pkg::OFF_IRQ_EN, 32'h00, acx_pkg::RESP_OKAY);
		chk({31'h0, irq}, 32'h0, "interrupt masked");
		wr(acx_pkg::OFF_IRQ_EN, 32'h08, acx_pkg::RESP_OKAY);
		chk({31'h0, irq}, 32'h1, "interrupt unmasked");
		wr(acx_pkg::OFF_IRQ_CLR, 32'h08, acx_pkg::RESP_OKAY);
		chk({31'h0, irq}, 32'h0, "interrupt cleared");
		$display("interrupt test done");
		complete_run();
	end
endmodule : test_acx_core
`default_nettype wire
